//--- rtl/ccog_map.vh
// Register map, field positions and reset values of the clock output,
// trim and clock event interrupt block.
// Assumes a 32-bit APB slave; every register takes one aligned word.
`ifndef CCOG_MAP_VH
`define CCOG_MAP_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CCOG_ADDR_W              8
`define CCOG_OFS_FLAGS           8'h00
`define CCOG_OFS_IRQ_EN          8'h04
`define CCOG_OFS_OUT_CTRL        8'h08
`define CCOG_OFS_TRIM            8'h0C
`define CCOG_OFS_PROTECT         8'h10

// ***************************************************************
// Event flag and enable layout (same for both registers)
// ***************************************************************
`define CCOG_EVT_W               6
`define CCOG_EVT_MASK            6'h37
`define CCOG_BIT_INT_STABLE      0
`define CCOG_BIT_SLOW_STABLE     1
`define CCOG_BIT_FAST_STABLE     2
`define CCOG_BIT_TRIM_DONE       4
`define CCOG_BIT_SLOW_STOP       5

// ***************************************************************
// Output control layout
// ***************************************************************
`define CCOG_BIT_OUT_EN          0
`define CCOG_SRC_LSB             2
`define CCOG_SRC_MSB             3
`define CCOG_DIV_LSB             4
`define CCOG_DIV_MSB             6
`define CCOG_SRC_INT             2'h0
`define CCOG_SRC_SLOW            2'h1
`define CCOG_SRC_FAST            2'h2
`define CCOG_SRC_SYS             2'h3
`define CCOG_OUT_CTRL_RST        7'h00

// ***************************************************************
// Trim layout and write protection
// ***************************************************************
`define CCOG_INT_TRIM_LSB        0
`define CCOG_INT_TRIM_MSB        5
`define CCOG_FAST_TRIM_LSB       8
`define CCOG_FAST_TRIM_MSB       12
`define CCOG_PROTECT_KEY         16'h0096
`define CCOG_BIT_UNLOCKED        0

`endif

//--- rtl/ccog_out_div.v
// Clock output source selector and divider.
// Assumes the four source clock levels are sampled synchronously to pclk
// and are at most a quarter of the pclk rate.
`timescale 1ns/100ps
`include "ccog_map.vh"

module ccog_out_div #(
    parameter CNT_W = 14
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clk_en,
    input  wire [3:0] src_level,
    input  wire [1:0] src_sel,
    input  wire [2:0] div_code,
    input  wire       out_en,
    input  wire       standby,
    output reg        clk_out
);

    // ***************************************************************
    // Half period in source edges, minus one
    // ***************************************************************
    function [CNT_W-1:0] half_limit;
        input [1:0] sel;
        input [2:0] code;
        reg   [15:0] ratio;
        begin
            ratio = 16'h0001;
            if (sel == `CCOG_SRC_SLOW) begin
                case (code)
                    3'h4:    ratio = 16'h0100;
                    3'h5:    ratio = 16'h0400;
                    3'h6:    ratio = 16'h1000;
                    3'h7:    ratio = 16'h8000;
                    default: ratio = 16'h0001 << code;
                endcase
            end else begin
                ratio = 16'h0001 << code;
            end
            half_limit = ratio[CNT_W:1] - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    reg  [3:0]       src_q_reg;
    reg              sel_prev_reg;
    reg  [CNT_W-1:0] cnt_reg;
    reg              tog_reg;
    reg  [4:0]       cfg_prev_reg;
    wire             sel_level = src_q_reg[src_sel];
    wire             rise      = sel_level & ~sel_prev_reg;
    wire             bypass    = (div_code == 3'h0);
    wire             reserved  = (src_sel == `CCOG_SRC_SYS) && !bypass;
    wire             stopped   = (src_sel == `CCOG_SRC_SYS) && standby;
    wire [4:0]       cfg_now   = {src_sel, div_code};

    // Edge counting divider; restarts when source or ratio changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q_reg    <= 4'h0;
            sel_prev_reg <= 1'b0;
            cnt_reg      <= {CNT_W{1'b0}};
            tog_reg      <= 1'b0;
            cfg_prev_reg <= 5'h00;
        end else if (clk_en) begin
            src_q_reg    <= src_level;
            sel_prev_reg <= sel_level;
            cfg_prev_reg <= cfg_now;
            if (cfg_now != cfg_prev_reg) begin
                cnt_reg <= {CNT_W{1'b0}};
                tog_reg <= 1'b0;
            end else if (rise) begin
                if (cnt_reg == half_limit(src_sel, div_code)) begin // [R6] [R7]
                    cnt_reg <= {CNT_W{1'b0}};
                    tog_reg <= ~tog_reg;
                end else begin
                    cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Output gate; enable acts at once, so a short pulse is possible
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out <= 1'b0;
        end else if (clk_en) begin
            if (!out_en || reserved || stopped) begin // [R9] [R10] [R8]
                clk_out <= 1'b0;
            end else if (bypass) begin
                clk_out <= sel_level; // [R5]
            end else begin
                clk_out <= tog_reg;
            end
        end
    end

endmodule

//--- rtl/ccog_top.v
// Clock output, oscillator trim and clock event interrupt block.
// Assumes an APB master on pclk and event pulses synchronous to pclk.
//
// Overview of operation
// [R1] Two enable bits gate the slow oscillator stop and internal trim done interrupts.
// [R2] Bits 2, 1 and 0 of the enable register gate fast, slow and internal stable events.
// [R3] Each event flag is set by its event and cleared only by writing one to it.
// [R4] The interrupt line is high while any flag is set together with its enable bit.
// [R5] The two-bit source field picks internal, slow, fast or system clock for the output.
// [R6] For internal and fast sources the divide code n divides by two to the power n.
// [R7] The slow source divides by 1, 2, 4, 8, 256, 1024, 4096, 32768; system only by 1.
// [R8] With the system clock selected the output stops during sleep or halt standby.
// [R9] The output enable bit drives the divided clock out when set and blocks it when clear.
// [R10] The enable is not aligned to the output clock, so a short pulse may appear.
// [R11] A five-bit trim field raises the fast oscillator frequency as its value rises.
// [R12] A six-bit trim field raises the internal oscillator frequency as its value rises.
// [R13] Both trim fields take factory values after reset and are writable only when unlocked.
// [R14] Software changes a trim field only while the trimmed oscillator is stopped.
`timescale 1ns/100ps
`include "ccog_map.vh"

module ccog_top #(
    parameter DIV_CNT_W = 14
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        slow_osc_stop_evt,
    input  wire        int_osc_trim_done_evt,
    input  wire        fast_osc_stable_evt,
    input  wire        slow_osc_stable_evt,
    input  wire        int_osc_stable_evt,
    input  wire        internal_osc_clock,
    input  wire        low_speed_clock,
    input  wire        high_speed_clock,
    input  wire        system_clock,
    input  wire        standby_mode,
    input  wire [4:0]  fast_osc_trim_fuse,
    input  wire [5:0]  int_osc_trim_fuse,
    output reg  [4:0]  fast_osc_trim,
    output reg  [5:0]  int_osc_trim,
    output reg         clock_irq,
    output wire        external_clock_output
);

    // ***************************************************************
    // State
    // ***************************************************************
    reg  [`CCOG_EVT_W-1:0] clock_event_flags_reg;
    reg  [`CCOG_EVT_W-1:0] clock_event_flags_next;
    reg  [`CCOG_EVT_W-1:0] clock_event_irq_enable_reg;
    reg  [2:0]             out_clock_divide_reg;
    reg  [1:0]             out_clock_source_reg;
    reg                    out_clock_enable_reg;
    reg                    unlocked_reg;
    reg                    trim_loaded_reg;
    reg  [31:0]            rdata_next;
    reg                    rerr_next;
    wire [`CCOG_EVT_W-1:0] evt_in;
    wire [`CCOG_ADDR_W-1:0] addr;
    wire                   setup;
    wire                   access;
    wire                   wr;
    wire                   wr_flags;
    wire                   wr_en;
    wire                   wr_ctrl;
    wire                   wr_trim;
    wire                   wr_prot;
    wire                   high_zero;

    // ***************************************************************
    // APB decode
    // ***************************************************************
    // Registers sit at word offsets below 0x20; higher address bits must be zero
    assign addr      = paddr[`CCOG_ADDR_W-1:0];
    assign high_zero = (paddr[31:`CCOG_ADDR_W] == 24'h000000) && (paddr[1:0] == 2'h0);
    assign setup     = psel && !penable;
    // Access completes only at the edge where our registered pready is high
    assign access    = psel && penable && pready;
    assign wr        = access && pwrite && !pslverr;
    assign wr_flags  = wr && (addr == `CCOG_OFS_FLAGS);
    assign wr_en     = wr && (addr == `CCOG_OFS_IRQ_EN);
    assign wr_ctrl   = wr && (addr == `CCOG_OFS_OUT_CTRL);
    assign wr_trim   = wr && (addr == `CCOG_OFS_TRIM);
    assign wr_prot   = wr && (addr == `CCOG_OFS_PROTECT);

    // Read mux and error decision, captured during the setup cycle
    always @* begin
        rdata_next = 32'h0000_0000;
        rerr_next  = 1'b0;
        if (!high_zero) begin
            rerr_next = 1'b1;
        end else begin
            case (addr)
                `CCOG_OFS_FLAGS: begin
                    rdata_next[`CCOG_EVT_W-1:0] = clock_event_flags_reg;
                end
                `CCOG_OFS_IRQ_EN: begin
                    rdata_next[`CCOG_EVT_W-1:0] = clock_event_irq_enable_reg;
                end
                `CCOG_OFS_OUT_CTRL: begin
                    rdata_next[`CCOG_DIV_MSB:`CCOG_DIV_LSB] = out_clock_divide_reg;
                    rdata_next[`CCOG_SRC_MSB:`CCOG_SRC_LSB] = out_clock_source_reg;
                    rdata_next[`CCOG_BIT_OUT_EN]            = out_clock_enable_reg;
                end
                `CCOG_OFS_TRIM: begin
                    rdata_next[`CCOG_FAST_TRIM_MSB:`CCOG_FAST_TRIM_LSB] = fast_osc_trim;
                    rdata_next[`CCOG_INT_TRIM_MSB:`CCOG_INT_TRIM_LSB]   = int_osc_trim;
                end
                `CCOG_OFS_PROTECT: begin
                    rdata_next[`CCOG_BIT_UNLOCKED] = unlocked_reg;
                end
                default: begin
                    rerr_next = 1'b1;
                end
            endcase
        end
    end

    // Bus answer flops; one fixed wait-free access phase per transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            if (setup) begin
                pready  <= 1'b1;
                pslverr <= rerr_next;
                prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            end else if (access) begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
        end
    end

    // ***************************************************************
    // Event flags and interrupt
    // ***************************************************************
    assign evt_in = {slow_osc_stop_evt, int_osc_trim_done_evt, 1'b0,
                     fast_osc_stable_evt, slow_osc_stable_evt, int_osc_stable_evt};

    // Write-one clears; a new event in the same cycle keeps the flag set
    always @* begin
        clock_event_flags_next = clock_event_flags_reg;
        if (wr_flags) begin
            clock_event_flags_next = clock_event_flags_next &
                                     ~pwdata[`CCOG_EVT_W-1:0]; // [R3]
        end
        clock_event_flags_next = (clock_event_flags_next | evt_in) & `CCOG_EVT_MASK; // [R3]
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_event_flags_reg      <= 6'h00;
            clock_event_irq_enable_reg <= 6'h00;
            clock_irq                  <= 1'b0;
        end else if (clk_en) begin
            clock_event_flags_reg <= clock_event_flags_next;
            if (wr_en) begin
                // Only the five defined enable bits are stored
                clock_event_irq_enable_reg <= pwdata[`CCOG_EVT_W-1:0] & `CCOG_EVT_MASK; // [R1] [R2]
            end
            // Level from next-state values so the line tracks flags with no lag
            clock_irq <= |(clock_event_flags_next &
                           (wr_en ? (pwdata[`CCOG_EVT_W-1:0] & `CCOG_EVT_MASK)
                                  : clock_event_irq_enable_reg)); // [R4]
        end
    end

    // ***************************************************************
    // Output clock control
    // ***************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_clock_divide_reg <= 3'h0;
            out_clock_source_reg <= 2'h0;
            out_clock_enable_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                out_clock_divide_reg <= pwdata[`CCOG_DIV_MSB:`CCOG_DIV_LSB]; // [R6] [R7]
                out_clock_source_reg <= pwdata[`CCOG_SRC_MSB:`CCOG_SRC_LSB]; // [R5]
                out_clock_enable_reg <= pwdata[`CCOG_BIT_OUT_EN]; // [R9]
            end
        end
    end

    ccog_out_div #(
        .CNT_W (DIV_CNT_W)
    ) u_out_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .src_level ({system_clock, high_speed_clock, low_speed_clock, internal_osc_clock}),
        .src_sel   (out_clock_source_reg),
        .div_code  (out_clock_divide_reg),
        .out_en    (out_clock_enable_reg),
        .standby   (standby_mode),
        .clk_out   (external_clock_output)
    );

    // ***************************************************************
    // Write protection and trim
    // ***************************************************************
    // Key write unlocks, any other value locks again
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlocked_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_prot) begin
                unlocked_reg <= (pwdata[15:0] == `CCOG_PROTECT_KEY); // [R13]
            end
        end
    end

    // Fuse values are caught after reset release, never under reset itself.
    // Software must stop the oscillator first; nothing here checks that.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_loaded_reg <= 1'b0;
            fast_osc_trim   <= 5'h00;
            int_osc_trim    <= 6'h00;
        end else if (clk_en) begin
            if (!trim_loaded_reg) begin
                trim_loaded_reg <= 1'b1;
                fast_osc_trim   <= fast_osc_trim_fuse; // [R13]
                int_osc_trim    <= int_osc_trim_fuse; // [R13]
            end else if (wr_trim && unlocked_reg) begin
                // [R14] relied upon: oscillator is idle while trim changes
                fast_osc_trim <= pwdata[`CCOG_FAST_TRIM_MSB:`CCOG_FAST_TRIM_LSB]; // [R11]
                int_osc_trim  <= pwdata[`CCOG_INT_TRIM_MSB:`CCOG_INT_TRIM_LSB]; // [R12]
            end
        end
    end

endmodule

//--- tb/ccog_top_properties.sv
// Checker for the clock output, trim and clock event interrupt block.
// Assumes it is bound into ccog_top and sees only that module's ports.
`timescale 1ns/100ps

module ccog_top_props #(
    parameter DIV_CNT_W = 14
) (
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        slow_osc_stop_evt,
    input wire        int_osc_trim_done_evt,
    input wire        fast_osc_stable_evt,
    input wire        slow_osc_stable_evt,
    input wire        int_osc_stable_evt,
    input wire [5:0]  int_osc_trim_fuse,
    input wire [5:0]  int_osc_trim,
    input wire        clock_irq
);
    // ****************
    // Helper logic
    // ****************
    // Completed writes and any event; named so that $past sees plain signals
    wire wr_acc = psel & penable & pwrite & pready & clk_en;
    wire trim_wr = wr_acc & (paddr == 32'h0000000C);
    wire evt_any = slow_osc_stop_evt | int_osc_trim_done_evt | fast_osc_stable_evt
                 | slow_osc_stable_evt | int_osc_stable_evt;
    reg  boot_q;

    // High until the first enabled edge after reset, when trims load
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            boot_q <= 1'b1;
        else if (clk_en)
            boot_q <= 1'b0;
    end

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ans_next_a: assert property (psel && !penable && clk_en |=> pready)
        else $error("no answer after setup");
    ans_single_a: assert property (pready && clk_en |=> !pready)
        else $error("answer held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    misalign_err_a: assert property (psel && !penable && clk_en && paddr[1:0] != 2'h0
        |=> pslverr) else $error("misaligned access accepted");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    irq_rise_a: assert property ($rose(clock_irq) |-> $past(evt_any) || $past(psel))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(clock_irq) |-> $past(wr_acc))
        else $error("interrupt fell without write");
    trim_boot_a: assert property (boot_q && clk_en |=> int_osc_trim == $past(int_osc_trim_fuse))
        else $error("trim did not load factory value");
    trim_hold_a: assert property ($changed(int_osc_trim) |-> $past(boot_q) || $past(trim_wr))
        else $error("trim changed without write");
endmodule

bind ccog_top ccog_top_props #(.DIV_CNT_W(DIV_CNT_W)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_stop_evt(slow_osc_stop_evt), .int_osc_trim_done_evt(int_osc_trim_done_evt),
    .fast_osc_stable_evt(fast_osc_stable_evt), .slow_osc_stable_evt(slow_osc_stable_evt),
    .int_osc_stable_evt(int_osc_stable_evt), .int_osc_trim_fuse(int_osc_trim_fuse),
    .int_osc_trim(int_osc_trim), .clock_irq(clock_irq)
);

//--- tb/ccog_top_bench.sv
// Self-checking bench for the clock output, trim and event interrupt block.
// Assumes ccog_top and its register map header; source clocks are pclk divisions.
`timescale 1ns/100ps
`include "ccog_map.vh"

module ccog_top_bench;
    reg         pclk = 1'b0, presetn, psel, penable, pwrite, standby, err, ce;
    reg  [31:0] paddr, pwdata, seed, rdat, v;
    reg  [5:0]  evt, ifuse;
    reg  [4:0]  ffuse, src_cnt = 5'h00;
    wire [31:0] prdata;
    wire        pready, pslverr, clock_irq, ext_out;
    wire [4:0]  fast_osc_trim;
    wire [5:0]  int_osc_trim;
    integer     num_errors, comparisons, i, c, s, k;

    ccog_top uut (
        .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_osc_stop_evt(evt[5]), .int_osc_trim_done_evt(evt[4]),
        .fast_osc_stable_evt(evt[2]), .slow_osc_stable_evt(evt[1]),
        .int_osc_stable_evt(evt[0]), .internal_osc_clock(src_cnt[1]),
        .low_speed_clock(src_cnt[2]), .high_speed_clock(src_cnt[3]),
        .system_clock(src_cnt[4]), .standby_mode(standby), .fast_osc_trim_fuse(ffuse),
        .int_osc_trim_fuse(ifuse), .fast_osc_trim(fast_osc_trim),
        .int_osc_trim(int_osc_trim), .clock_irq(clock_irq), .external_clock_output(ext_out)
    );

    // ****************
    // Clocks
    // ****************
    // Sources run at pclk/4, /8, /16, /32 to stay within the sampling limit
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        src_cnt <= src_cnt + 5'h01;
    end

    // ****************
    // Helpers
    // ****************
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Division ratio by source and code; slow upper codes jump
    function integer ratio(input integer sr, input integer cd);
        if (sr == 1 && cd > 3)
            ratio = (cd == 4) ? 256 : (cd == 5) ? 1024 : (cd == 6) ? 4096 : 32768;
        else
            ratio = 1 << cd;
    endfunction

    task chk(input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t expected %h got %h", $time, exp, got);
            end
        end
    endtask

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {24'h000000, a};
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rdat = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdc(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(exp, rdat);
        end
    endtask

    // Counts output rising edges over four expected periods, one edge of slack
    task measure(input integer per, input integer exp);
        integer t, n;
        reg     prev;
        begin
            repeat (per + 8) @(posedge pclk);
            n = 0;
            prev = ext_out;
            for (t = 0; t < 4 * per; t = t + 1) begin
                @(posedge pclk);
                if (ext_out === 1'b1 && prev === 1'b0)
                    n = n + 1;
                prev = ext_out;
            end
            chk(exp, (exp > 0 && n >= exp - 1 && n <= exp + 1) ? exp : n);
            if (exp == 0)
                chk(32'h0, {31'h0, ext_out});
        end
    endtask

    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // ****************
    // Tests
    // ****************
    // Watchdog at 60k cycles, well above the expected 40k
    initial begin
        #1500000;
        $display("[FAIL] %0t watchdog expired", $time);
        num_errors = num_errors + 1;
        final_report;
    end

    // Main sequence
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; ce = 1;
        pwdata = 0; evt = 0; standby = 0; num_errors = 0; comparisons = 0;
        seed = lfsr(32'h63FF);
        ifuse = seed[5:0];
        ffuse = seed[12:8];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CCOG_OFS_IRQ_EN, 32'h0);
        rdc(`CCOG_OFS_OUT_CTRL, 32'h0);
        rdc(`CCOG_OFS_FLAGS, 32'h0);
        rdc(`CCOG_OFS_TRIM, {19'h0, ffuse, 2'h0, ifuse});
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            apb(1'b1, `CCOG_OFS_IRQ_EN, seed);
            rdc(`CCOG_OFS_IRQ_EN, seed & 32'h37);
            apb(1'b1, `CCOG_OFS_OUT_CTRL, seed >> 8);
            rdc(`CCOG_OFS_OUT_CTRL, (seed >> 8) & 32'h7D);
        end
        apb(1'b1, `CCOG_OFS_IRQ_EN, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'h1, {31'h0, err});
        apb(1'b0, 8'h06, 32'h0);
        chk(32'h1, {31'h0, err});
        $display("test regs done");
        apb(1'b1, `CCOG_OFS_TRIM, ~seed);
        rdc(`CCOG_OFS_TRIM, {19'h0, ffuse, 2'h0, ifuse});
        apb(1'b1, `CCOG_OFS_PROTECT, {16'h0, `CCOG_PROTECT_KEY});
        for (c = 0; c < 3; c = c + 1) begin
            seed = lfsr(seed);
            v = (c == 0) ? 32'h1F3F : (c == 1) ? 32'h0 : seed;
            // Oscillators are taken as stopped here while the trim moves
            apb(1'b1, `CCOG_OFS_TRIM, v);
            rdc(`CCOG_OFS_TRIM, v & 32'h1F3F);
            chk(v[12:8], {27'h0, fast_osc_trim});
            chk(v[5:0], {26'h0, int_osc_trim});
        end
        apb(1'b1, `CCOG_OFS_PROTECT, 32'h0);
        $display("test trim done");
        for (i = 0; i < 6; i = i + 1) begin
            if (i != 3) begin
                @(posedge pclk);
                evt <= 6'h01 << i;
                @(posedge pclk);
                evt <= 6'h00;
                rdc(`CCOG_OFS_FLAGS, 32'h1 << i);
                chk(32'h0, {31'h0, clock_irq});
                apb(1'b1, `CCOG_OFS_IRQ_EN, 32'h1 << i);
                repeat (2) @(posedge pclk);
                #1;
                chk(32'h1, {31'h0, clock_irq});
                apb(1'b1, `CCOG_OFS_FLAGS, 32'h0);
                rdc(`CCOG_OFS_FLAGS, 32'h1 << i);
                apb(1'b1, `CCOG_OFS_FLAGS, 32'h1 << i);
                rdc(`CCOG_OFS_FLAGS, 32'h0);
                chk(32'h0, {31'h0, clock_irq});
                apb(1'b1, `CCOG_OFS_IRQ_EN, 32'h0);
            end
        end
        // Clock enable low freezes state, so an event pulse is lost
        ce <= 1'b0;
        evt <= 6'h01;
        @(posedge pclk);
        evt <= 6'h00;
        ce <= 1'b1;
        rdc(`CCOG_OFS_FLAGS, 32'h0);
        $display("test events done");
        for (c = 0; c < 24; c = c + 1) begin
            s = c / 8;
            k = c % 8;
            if (!(s == 1 && k > 4)) begin
                apb(1'b1, `CCOG_OFS_OUT_CTRL, (k << 4) | (s << 2) | 1);
                measure((4 << s) * ratio(s, k), 4);
            end
        end
        apb(1'b1, `CCOG_OFS_OUT_CTRL, 32'h0D);
        measure(32, 4);
        apb(1'b1, `CCOG_OFS_OUT_CTRL, 32'h1D);
        measure(64, 0);
        apb(1'b1, `CCOG_OFS_OUT_CTRL, 32'h0D);
        standby <= 1'b1;
        measure(64, 0);
        standby <= 1'b0;
        apb(1'b1, `CCOG_OFS_OUT_CTRL, 32'h0C);
        measure(64, 0);
        $display("test output clock done");
        final_report;
    end
endmodule
